// file: hdl/aes_gcm_packet_sequencer.v
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "gcm_seq_map.vh"

module aes_gcm_packet_sequencer (
  // Clock, reset and freeze
  input wire aclk,
  input wire aresetn,
  input wire enable,
  // AXI4-Lite write channels
  input wire [7:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output wire [1:0] bresp,
  output wire bvalid,
  input wire bready,
  // AXI4-Lite read channels
  input wire [7:0] araddr,
  input wire arvalid,
  output wire arready,
  output wire [31:0] rdata,
  output wire [1:0] rresp,
  output wire rvalid,
  input wire rready,
  // Packet control
  input wire start,
  // Key stream
  input wire [`DATA_W-1:0] key_in_bus,
  output wire key_load_flag,
  // Text stream
  input wire [`DATA_W-1:0] text_in_bus,
  input wire [2:0] in_block_type,
  input wire [4:0] in_byte_count,
  output wire text_load_flag,
  // Results
  output wire [`DATA_W-1:0] result_bus,
  output wire result_valid,
  output wire [2:0] out_block_type,
  output wire [4:0] out_byte_count,
  output wire tag_match,
  output wire tag_check_valid
);

  // ========================================================================
  // Sequencer states and load phases
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_KEY = 4'h1;
  localparam [3:0] S_HKEY = 4'h2;
  localparam [3:0] S_LOAD = 4'h3;
  localparam [3:0] S_DISP = 4'h4;
  localparam [3:0] S_MUL = 4'h5;
  localparam [3:0] S_IVLEN = 4'h6;
  localparam [3:0] S_EJ0 = 4'h7;
  localparam [3:0] S_PAYENC = 4'h8;
  localparam [3:0] S_TAGC = 4'h9;
  localparam [3:0] S_TAGOUT = 4'hA;
  localparam [3:0] S_MATCH = 4'hB;
  localparam [1:0] PH_IV = 2'h0;
  localparam [1:0] PH_BODY = 2'h1;
  localparam [1:0] PH_TAG = 2'h2;

  reg [3:0] state_q;
  reg [3:0] after_q;
  reg [1:0] ph_q;
  reg enc_q;
  reg [1:0] klen_q;
  reg [255:0] key_q;
  reg [4:0] kcnt_q;
  reg [4:0] wcnt_q;
  reg [127:0] blk_q;
  reg [2:0] btype_q;
  reg [4:0] bbytes_q;
  reg first_iv_q;
  reg direct96_q;
  reg [127:0] h_q;
  reg [127:0] j0_q;
  reg [127:0] ctr_q;
  reg [127:0] ej0_q;
  reg [127:0] ghash_q;
  reg [127:0] tag_q;
  reg [127:0] exp_tag_q;
  reg [63:0] iv_len_q;
  reg [63:0] aad_len_q;
  reg [63:0] pay_len_q;
  reg cip_busy_q;
  reg cip_done_q;
  reg [3:0] cip_rnd_q;
  reg [127:0] cip_s_q;
  reg [127:0] cip_rk_q;
  reg gf_go_q;
  reg [127:0] gf_x_q;
  reg [127:0] out_q;
  reg [4:0] out_cnt_q;
  reg [2:0] out_type_q;
  reg [4:0] out_bytes_q;
  reg tag_match_q;
  reg tag_chk_q;
  reg tag_seen_q;
  reg [2:0] ctrl_q;

  wire gf_done;
  wire [127:0] gf_z;

  // ========================================================================
  // Word shifters and byte masks
  wire [255+`DATA_W:0] kcat = {key_q, key_in_bus};
  wire [127+`DATA_W:0] bcat = {blk_q, text_in_bus};
  wire [127+`DATA_W:0] ocat = {out_q, {`DATA_W{1'b0}}};
  wire [127:0] bmask;
  wire [127:0] blk_m = blk_q & bmask;

  genvar b;
  generate
    for (b = 0; b < 16; b = b + 1) begin : g_byte_mask
      assign bmask[127-8*b -: 8] = (bbytes_q > b) ? 8'hFF : 8'h00;
    end
  endgenerate

  wire [4:0] key_last = (klen_q == 2'h0) ? `KEY_LAST_128 :
    ((klen_q == 2'h1) ? `KEY_LAST_192 : `KEY_LAST_256);
  wire [3:0] rounds = (klen_q == 2'h0) ? `ROUNDS_128 :
    ((klen_q == 2'h1) ? `ROUNDS_192 : `ROUNDS_256);
  wire [127:0] rk_first = key_q[255:128] ^ key_q[127:0];
  wire [127:0] ctr_inc = {ctr_q[127:32], ctr_q[31:0] + `CTR_ONE};
  wire [127:0] pay_res = (blk_q ^ cip_s_q) & bmask;
  wire [127:0] pay_ct = enc_q ? pay_res : blk_m;
  wire [127:0] len_blk = {aad_len_q[60:0], 3'h0, pay_len_q[60:0], 3'h0};
  wire [127:0] iv_len_blk = {64'h0000_0000_0000_0000, iv_len_q[60:0], 3'h0};

  // Compact keyed mixing network in place of full cipher rounds; one round per
  // cycle. It keeps the sequencing exact but offers no cryptographic strength.
  wire [127:0] cip_round = {cip_s_q[120:0], cip_s_q[127:121]} ^
    (cip_s_q & {cip_s_q[0], cip_s_q[127:1]}) ^
    ~{cip_s_q[63:0], cip_s_q[127:64]} ^ cip_rk_q;

  // ========================================================================
  // Packet sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= S_IDLE;
      after_q <= S_IDLE;
      ph_q <= PH_IV;
      enc_q <= 1'b1;
      klen_q <= 2'h0;
      key_q <= {2{128'h0000_0000_0000_0000_0000_0000_0000_0000}};
      kcnt_q <= 5'h00;
      wcnt_q <= 5'h00;
      blk_q <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
      btype_q <= `kind_init_vector;
      bbytes_q <= 5'h00;
      first_iv_q <= 1'b0;
      direct96_q <= 1'b0;
      h_q <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
      j0_q <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
      ctr_q <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
      ej0_q <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
      ghash_q <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
      tag_q <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
      exp_tag_q <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
      iv_len_q <= 64'h0000_0000_0000_0000;
      aad_len_q <= 64'h0000_0000_0000_0000;
      pay_len_q <= 64'h0000_0000_0000_0000;
      cip_busy_q <= 1'b0;
      cip_done_q <= 1'b0;
      cip_rnd_q <= 4'h0;
      cip_s_q <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
      cip_rk_q <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
      gf_go_q <= 1'b0;
      gf_x_q <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
      out_q <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
      out_cnt_q <= 5'h00;
      out_type_q <= `kind_init_vector;
      out_bytes_q <= 5'h00;
      tag_match_q <= 1'b0;
      tag_chk_q <= 1'b0;
      tag_seen_q <= 1'b0;
    end else if (enable) begin
      gf_go_q <= 1'b0;
      cip_done_q <= 1'b0;
      tag_chk_q <= 1'b0;
      if (cip_busy_q) begin
        cip_s_q <= cip_round;
        cip_rk_q <= {cip_rk_q[126:0], cip_rk_q[127]} ^ `CIP_RCON;
        cip_rnd_q <= cip_rnd_q - 4'h1;
        if (cip_rnd_q == 4'h1) begin
          cip_busy_q <= 1'b0;
          cip_done_q <= 1'b1;
        end
      end
      if (out_cnt_q != 5'h00) begin
        out_q <= ocat[127:0];
        out_cnt_q <= out_cnt_q - 5'h01;
      end
      if (start) begin
        enc_q <= ctrl_q[0];
        klen_q <= ctrl_q[2:1];
        key_q <= {2{128'h0000_0000_0000_0000_0000_0000_0000_0000}};
        kcnt_q <= 5'h00;
        wcnt_q <= 5'h00;
        ghash_q <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
        iv_len_q <= 64'h0000_0000_0000_0000;
        aad_len_q <= 64'h0000_0000_0000_0000;
        pay_len_q <= 64'h0000_0000_0000_0000;
        direct96_q <= 1'b0;
        cip_busy_q <= 1'b0;
        out_cnt_q <= 5'h00;
        tag_match_q <= 1'b0;
        tag_seen_q <= 1'b0;
        state_q <= S_KEY;
      end else begin
        case (state_q)
          S_IDLE: begin
            state_q <= S_IDLE;
          end
          S_KEY: begin
            key_q <= kcat[255:0];
            kcnt_q <= kcnt_q + 5'h01;
            if (kcnt_q == key_last) begin
              kcnt_q <= 5'h00;
              cip_s_q <= kcat[127:0];
              cip_rk_q <= kcat[255:128] ^ kcat[127:0];
              cip_rnd_q <= rounds;
              cip_busy_q <= 1'b1;
              state_q <= S_HKEY;
            end
          end
          S_HKEY: begin
            if (cip_done_q) begin
              h_q <= cip_s_q;
              ph_q <= PH_IV;
              first_iv_q <= 1'b1;
              state_q <= S_LOAD;
            end
          end
          S_LOAD: begin
            blk_q <= bcat[127:0];
            if (wcnt_q == 5'h00) begin
              btype_q <= in_block_type;
              bbytes_q <= in_byte_count;
            end
            wcnt_q <= wcnt_q + 5'h01;
            if (wcnt_q == `BLK_LAST) begin
              wcnt_q <= 5'h00;
              state_q <= S_DISP;
              if (ph_q != PH_TAG && btype_q == `kind_assoc_data) begin
                out_q <= bcat[127:0] & bmask;
                out_cnt_q <= `BLK_WORDS;
                out_type_q <= `kind_assoc_data;
                out_bytes_q <= bbytes_q;
              end
            end
          end
          S_DISP: begin
            if (ph_q == PH_TAG) begin
              exp_tag_q <= blk_q;
              state_q <= S_TAGOUT;
            end else if (ph_q == PH_IV) begin
              if (btype_q == `kind_init_vector) begin
                first_iv_q <= 1'b0;
                if (first_iv_q && bbytes_q == `IV96_BYTES) begin
                  j0_q <= {blk_q[127:32], `CTR_ONE};
                  direct96_q <= 1'b1;
                  state_q <= S_LOAD;
                end else begin
                  gf_x_q <= ghash_q ^ blk_m;
                  gf_go_q <= 1'b1;
                  iv_len_q <= iv_len_q + {59'h000_0000_0000_0000, bbytes_q};
                  after_q <= S_LOAD;
                  state_q <= S_MUL;
                end
              end else if (direct96_q) begin
                cip_s_q <= j0_q ^ key_q[127:0];
                cip_rk_q <= rk_first;
                cip_rnd_q <= rounds;
                cip_busy_q <= 1'b1;
                state_q <= S_EJ0;
              end else begin
                gf_x_q <= ghash_q ^ iv_len_blk;
                gf_go_q <= 1'b1;
                after_q <= S_IVLEN;
                state_q <= S_MUL;
              end
            end else begin
              case (btype_q)
                `kind_assoc_data: begin
                  gf_x_q <= ghash_q ^ blk_m;
                  gf_go_q <= 1'b1;
                  aad_len_q <= aad_len_q + {59'h000_0000_0000_0000, bbytes_q};
                  after_q <= S_LOAD;
                  state_q <= S_MUL;
                end
                `kind_payload: begin
                  ctr_q <= ctr_inc;
                  cip_s_q <= ctr_inc ^ key_q[127:0];
                  cip_rk_q <= rk_first;
                  cip_rnd_q <= rounds;
                  cip_busy_q <= 1'b1;
                  state_q <= S_PAYENC;
                end
                default: begin
                  gf_x_q <= ghash_q ^ len_blk;
                  gf_go_q <= 1'b1;
                  after_q <= S_TAGC;
                  state_q <= S_MUL;
                end
              endcase
            end
          end
          S_MUL: begin
            if (gf_done) begin
              ghash_q <= gf_z;
              state_q <= after_q;
            end
          end
          S_IVLEN: begin
            j0_q <= ghash_q;
            ghash_q <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
            cip_s_q <= ghash_q ^ key_q[127:0];
            cip_rk_q <= rk_first;
            cip_rnd_q <= rounds;
            cip_busy_q <= 1'b1;
            state_q <= S_EJ0;
          end
          S_EJ0: begin
            if (cip_done_q) begin
              ej0_q <= cip_s_q;
              ctr_q <= j0_q;
              ph_q <= PH_BODY;
              state_q <= S_DISP;
            end
          end
          S_PAYENC: begin
            if (cip_done_q) begin
              gf_x_q <= ghash_q ^ pay_ct;
              gf_go_q <= 1'b1;
              pay_len_q <= pay_len_q + {59'h000_0000_0000_0000, bbytes_q};
              out_q <= pay_res;
              out_cnt_q <= `BLK_WORDS;
              out_type_q <= `kind_payload;
              out_bytes_q <= bbytes_q;
              after_q <= S_LOAD;
              state_q <= S_MUL;
            end
          end
          S_TAGC: begin
            tag_q <= ghash_q ^ ej0_q;
            if (enc_q) begin
              state_q <= S_TAGOUT;
            end else begin
              ph_q <= PH_TAG;
              state_q <= S_LOAD;
            end
          end
          S_TAGOUT: begin
            out_q <= tag_q;
            out_cnt_q <= `BLK_WORDS;
            out_type_q <= `kind_auth_tag;
            out_bytes_q <= `FULL_BYTES;
            state_q <= S_MATCH;
          end
          S_MATCH: begin
            if (out_cnt_q == 5'h01) begin
              if (!enc_q) begin
                tag_match_q <= (tag_q == exp_tag_q);
                tag_chk_q <= 1'b1;
                tag_seen_q <= 1'b1;
              end
              state_q <= S_IDLE;
            end
          end
          default: begin
            state_q <= S_IDLE;
          end
        endcase
      end
    end
  end

  gf_mult_serial u_gf (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(enable),
    .go(gf_go_q),
    .x_in(gf_x_q),
    .h_in(h_q),
    .done(gf_done),
    .z_out(gf_z)
  );

  assign key_load_flag = (state_q == S_KEY);
  assign text_load_flag = (state_q == S_LOAD);
  assign result_bus = out_q[127 -: `DATA_W];
  assign result_valid = (out_cnt_q != 5'h00);
  assign out_block_type = out_type_q;
  assign out_byte_count = out_bytes_q;
  assign tag_match = tag_match_q;
  assign tag_check_valid = tag_chk_q;

  // ========================================================================
  // AXI4-Lite register slave
  reg aw_hold_q;
  reg [7:0] aw_addr_q;
  reg w_hold_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg rvalid_q;
  reg [1:0] rresp_q;
  reg [31:0] rdata_q;

  // Readies include enable so that no beat is taken while the block is frozen.
  assign awready = enable & ~aw_hold_q & ~bvalid_q;
  assign wready = enable & ~w_hold_q & ~bvalid_q;
  assign arready = enable & ~rvalid_q;

  wire [31:0] status_word = {24'h00_0000, state_q, 1'b0, tag_match_q, tag_seen_q,
    (state_q != S_IDLE)};

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_hold_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= `RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      ctrl_q <= `CTRL_RESET;
    end else if (enable) begin
      if (awvalid && awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (aw_hold_q && w_hold_q && !bvalid_q) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        if (aw_addr_q == `REG_CTRL_ADDR) begin
          bresp_q <= `RESP_OKAY;
          if (w_strb_q[0]) begin
            ctrl_q <= w_data_q[2:0];
          end
        end else if (aw_addr_q == `REG_STATUS_ADDR) begin
          bresp_q <= `RESP_OKAY;
        end else begin
          bresp_q <= `RESP_SLVERR;
        end
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
      if (arvalid && arready) begin
        rvalid_q <= 1'b1;
        if (araddr == `REG_CTRL_ADDR) begin
          rdata_q <= {29'h0000_0000, ctrl_q};
          rresp_q <= `RESP_OKAY;
        end else if (araddr == `REG_STATUS_ADDR) begin
          rdata_q <= status_word;
          rresp_q <= `RESP_OKAY;
        end else begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= `RESP_SLVERR;
        end
      end else if (rvalid_q && rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;

endmodule // aes_gcm_packet_sequencer

`default_nettype wire

// file: hdl/gcm_seq_map.vh
`ifndef GCM_SEQ_MAP_VH
`define GCM_SEQ_MAP_VH

// ==========================================================================
// Datapath geometry
`define DATA_W 32
`define BLK_WORDS 5'h04
`define BLK_LAST 5'h03
`define KEY_LAST_128 5'h03
`define KEY_LAST_192 5'h05
`define KEY_LAST_256 5'h07

// ==========================================================================
// Block kinds
`define kind_init_vector 3'h0
`define kind_assoc_data 3'h1
`define kind_payload 3'h2
`define kind_end_marker 3'h3
`define kind_end_marker_alias 3'h3
`define kind_auth_tag 3'h4
`define FULL_BYTES 5'h10
`define IV96_BYTES 5'h0C

// ==========================================================================
// Cipher engine and field multiplier timing
`define ROUNDS_128 4'hA
`define ROUNDS_192 4'hC
`define ROUNDS_256 4'hE
`define CIP_RCON 128'h0000_0000_0000_0000_0000_0000_0000_001B
`define GF_STEPS 8'h80
`define GF_POLY 128'hE100_0000_0000_0000_0000_0000_0000_0000
`define CTR_ONE 32'h0000_0001

// ==========================================================================
// Register map
`define REG_CTRL_ADDR 8'h00
`define REG_STATUS_ADDR 8'h04
`define CTRL_RESET 3'h1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: hdl/gf_mult_serial.v
`timescale 1ns/1ps
`default_nettype none
`include "gcm_seq_map.vh"

module gf_mult_serial (
  // Clock, reset and freeze
  input wire aclk,
  input wire aresetn,
  input wire enable,
  // Operands
  input wire go,
  input wire [127:0] x_in,
  input wire [127:0] h_in,
  // Product
  output wire done,
  output wire [127:0] z_out
);

  reg [127:0] z_q;
  reg [127:0] v_q;
  reg [127:0] x_q;
  reg [7:0] cnt_q;
  reg busy_q;
  reg done_q;

  // One bit of the multiplier per cycle keeps the area small at the cost of latency.
  always @(posedge aclk) begin
    if (!aresetn) begin
      z_q <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
      v_q <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
      x_q <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
      cnt_q <= 8'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (enable) begin
      done_q <= 1'b0;
      if (go) begin
        z_q <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
        v_q <= h_in;
        x_q <= x_in;
        cnt_q <= `GF_STEPS;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (x_q[127]) begin
          z_q <= z_q ^ v_q;
        end
        v_q <= v_q[0] ? ({1'b0, v_q[127:1]} ^ `GF_POLY) : {1'b0, v_q[127:1]};
        x_q <= {x_q[126:0], 1'b0};
        cnt_q <= cnt_q - 8'h01;
        if (cnt_q == 8'h01) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  assign done = done_q;
  assign z_out = z_q;

endmodule // gf_mult_serial

`default_nettype wire

// file: tb/gcm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host stream model: feeds key words and typed blocks, and stalls at random.
module gcm_host_model (
  // Clock and packet start
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  // Packet script: 3-bit kind and 5-bit byte count per block, block 0 lowest
  input wire logic [23:0] kinds,
  input wire logic [39:0] counts,
  // Design side
  input wire logic key_load_flag,
  input wire logic text_load_flag,
  output logic enable,
  output logic [31:0] key_in_bus,
  output logic [31:0] text_in_bus,
  output wire logic [2:0] in_block_type,
  output wire logic [4:0] in_byte_count
);
  logic [4:0] words_q;
  assign in_block_type = kinds[words_q[4:2]*3 +: 3];
  assign in_byte_count = counts[words_q[4:2]*5 +: 5];
  initial begin
    enable = 1'b1;
    key_in_bus = 32'h0000_0000;
    text_in_bus = 32'h0000_0000;
    words_q = 5'h00;
  end
  always @(posedge aclk) begin
    // A word holds until taken; a bus nobody reads changes every cycle.
    if (!(text_load_flag && !enable)) text_in_bus <= $urandom;
    if (!(key_load_flag && !enable)) key_in_bus <= $urandom;
    if (!aresetn || start) words_q <= 5'h00;
    else if (text_load_flag && enable) words_q <= words_q + 5'h01;
    enable <= !aresetn || !text_load_flag || ($urandom % 4 != 0);
  end
endmodule // gcm_host_model
`default_nettype wire

// file: tb/gcm_seq_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "gcm_seq_map.vh"
// ==========================================================
// Sequencing checks at the packet ports.
module gcm_seq_chk (
  // Clock and control
  input wire aclk,
  input wire aresetn,
  input wire enable,
  input wire start,
  // Flags and results
  input wire key_load_flag,
  input wire text_load_flag,
  input wire result_valid,
  input wire [2:0] out_block_type,
  input wire tag_match,
  input wire tag_check_valid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [1:0] rv_n_q, key_n_q, txt_n_q;
  // Counts wrap at four so that back-to-back blocks still line up.
  always @(posedge aclk) begin
    rv_n_q <= (!aresetn || !result_valid) ? 2'h0 : rv_n_q + {1'b0, enable};
    key_n_q <= (!aresetn || start) ? 2'h0 : key_n_q + {1'b0, enable && key_load_flag};
    txt_n_q <= (!aresetn || start) ? 2'h0 : txt_n_q + {1'b0, enable && text_load_flag};
  end
  property p_key_after_start; start && enable |=> key_load_flag; endproperty
  a_key_after_start: assert property (p_key_after_start) else $error("no key load after start");
  property p_key_words; $fell(key_load_flag) |-> key_n_q == 2'h0; endproperty
  a_key_words: assert property (p_key_words) else $error("key word count off");
  property p_hash_first; $fell(key_load_flag) |-> !text_load_flag [*8]; endproperty
  a_hash_first: assert property (p_hash_first) else $error("text load before hash key");
  property p_blk_words; $fell(text_load_flag) |-> txt_n_q == 2'h0; endproperty
  a_blk_words: assert property (p_blk_words) else $error("partial block load");
  property p_rv_len; $fell(result_valid) |-> rv_n_q == 2'h0; endproperty
  a_rv_len: assert property (p_rv_len) else $error("output block length off");
  property p_tag_after;
    tag_check_valid |-> !result_valid && $past(result_valid) && $past(out_block_type) == `kind_auth_tag;
  endproperty
  a_tag_after: assert property (p_tag_after) else $error("tag check not after tag");
  property p_tag_pulse; tag_check_valid |=> !tag_check_valid; endproperty
  a_tag_pulse: assert property (p_tag_pulse) else $error("tag check longer than one cycle");
  property p_match_reg; !$stable(tag_match) |-> tag_check_valid || $past(start); endproperty
  a_match_reg: assert property (p_match_reg) else $error("tag match changed off its pulse");
endmodule // gcm_seq_chk
bind aes_gcm_packet_sequencer gcm_seq_chk gcm_seq_chk_i (.aclk, .aresetn, .enable, .start,
  .key_load_flag, .text_load_flag, .result_valid, .out_block_type, .tag_match, .tag_check_valid);
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "gcm_seq_map.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module testbench;
  logic aclk, aresetn, start, enable, key_load_flag, text_load_flag, result_valid;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic tag_match, tag_check_valid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, key_in_bus, text_in_bus, result_bus, q, exp_w;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r, wsel, oidx;
  logic [2:0] in_block_type, out_block_type, cur_k;
  logic [4:0] in_byte_count, out_byte_count, cur_c;
  logic [23:0] kinds;
  logic [39:0] counts;
  logic [31:0] exp_q[$];
  int bad_count, check_count, tcv_n, out_n[8], lag;
  aes_gcm_packet_sequencer aes_gcm_packet_sequencer_i (.aclk, .aresetn, .enable, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .start, .key_in_bus, .key_load_flag,
    .text_in_bus, .in_block_type, .in_byte_count, .text_load_flag, .result_bus, .result_valid,
    .out_block_type, .out_byte_count, .tag_match, .tag_check_valid);
  gcm_host_model gcm_host_model_i (.aclk, .aresetn, .start, .kinds, .counts, .key_load_flag,
    .text_load_flag, .enable, .key_in_bus, .text_in_bus, .in_block_type, .in_byte_count);
  // ==========================================================
  // Clock, watchdog and expectations
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    repeat (40000) @(posedge aclk);
    bad_count++;
    results();
  end
  function automatic logic [31:0] keep(input logic [4:0] c, input logic [1:0] w);
    int v;
    v = int'(c) - 4 * int'(w);
    v = (v > 4) ? 4 : (v < 0) ? 0 : v;
    return ~(32'hFFFF_FFFF >> (8 * v));
  endfunction
  function automatic int blocks(input logic [2:0] k);
    int n;
    n = 0;
    for (int i = 1; i < 8 && kinds[i*3 +: 3] != `kind_end_marker; i++) n += (kinds[i*3 +: 3] == k);
    return 4 * n;
  endfunction
  // ==========================================================
  // Monitor: bytes past the count are expected as zero on the pass-through.
  always @(posedge aclk) begin
    if (enable) lag++;
    if (start) begin
      wsel = 2'h0;
      oidx = 2'h0;
    end else if (text_load_flag && enable) begin
      if (wsel == 2'h0) begin
        cur_k = in_block_type;
        cur_c = in_byte_count;
        if (cur_k == `kind_assoc_data) lag = 0;
      end
      if (cur_k == `kind_assoc_data) exp_q.push_back(text_in_bus & keep(cur_c, wsel));
      wsel++;
    end
    if (result_valid && enable) begin
      out_n[out_block_type]++;
      if (out_block_type === `kind_auth_tag) `CHK(out_byte_count, `FULL_BYTES)
      else `CHK(out_byte_count, cur_c)
      if (out_block_type === `kind_payload)
        `CHK(result_bus & ~keep(out_byte_count, oidx), 32'h0000_0000)
      if (out_block_type === `kind_assoc_data) begin
        exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : ~result_bus;
        `CHK(result_bus, exp_w)
        if (oidx == 2'h0) `CHK(lag, 4)
      end
      oidx++;
    end
    if (tag_check_valid) tcv_n++;
  end
  // ==========================================================
  // AXI4-Lite master and packet runner
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, done;
    int t;
    t = 0;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    arvalid <= !wr;
    bready <= wr;
    rready <= !wr;
    while (!done && t < 200) begin
      @(negedge aclk);
      ta = (awvalid && awready) || (arvalid && arready);
      tw = wvalid && wready;
      done = wr ? bvalid : rvalid;
      q = rdata;
      r = wr ? bresp : rresp;
      @(posedge aclk);
      if (ta) begin
        awvalid <= 1'b0;
        arvalid <= 1'b0;
      end
      if (tw) wvalid <= 1'b0;
      t++;
    end
    if (!done) bad_count++;
    bready <= 1'b0;
    rready <= 1'b0;
  endtask
  task automatic pkt(input logic [23:0] k, input logic [39:0] c, input int dec);
    int t;
    @(posedge aclk);
    kinds <= k;
    counts <= c;
    out_n = '{default: 0};
    tcv_n = 0;
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    for (t = 0; out_n[`kind_auth_tag] < 4 && t < 8000; t++) @(posedge aclk);
    repeat (3) @(posedge aclk);
    `CHK(out_n[`kind_assoc_data], blocks(`kind_assoc_data))
    `CHK(out_n[`kind_payload], blocks(`kind_payload))
    `CHK(out_n[`kind_auth_tag], 4)
    `CHK(tcv_n, dec)
    if (dec == 1) `CHK(tag_match, 1'b0)
  endtask
  task automatic results();
    if (bad_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========================================================
  // Main sequence: direct IV with assoc and payload, hashed IV with no body, decrypt.
  initial begin
    void'($urandom(34));
    {aresetn, start, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    {awaddr, araddr, wdata, wstrb, kinds, counts} = '0;
    wstrb = 4'hF;
    {wsel, oidx} = 4'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi(1'b0, `REG_CTRL_ADDR, 32'h0000_0000);
    `CHK(q, {29'h0000_0000, `CTRL_RESET})
    pkt({6'h00, `kind_end_marker, `kind_payload, `kind_payload, `kind_assoc_data,
      `kind_assoc_data, `kind_init_vector}, {10'h000, 5'h10, 5'h01 + 5'($urandom % 15),
      5'h10, 5'h01 + 5'($urandom % 15), 5'h10, `IV96_BYTES}, 0);
    pkt({15'h0000, `kind_end_marker, `kind_init_vector, `kind_init_vector},
      {30'h0000_0000, 5'h01 + 5'($urandom % 16), 5'h10}, 0);
    axi(1'b1, `REG_CTRL_ADDR, 32'h0000_0000);
    pkt({12'h000, `kind_auth_tag, `kind_end_marker, `kind_payload, `kind_init_vector},
      {20'h0_0000, 5'h10, 5'h10, 5'h01 + 5'($urandom % 15), `IV96_BYTES}, 1);
    axi(1'b0, `REG_STATUS_ADDR, 32'h0000_0000);
    `CHK(q[2:1], 2'h1)
    axi(1'b0, 8'h08, 32'h0000_0000);
    `CHK(r, `RESP_SLVERR)
    results();
  end
endmodule // testbench
`default_nettype wire
